// ==== verilog/rup_path.sv ====
// Functional notes
// - Shift register lets user logic read update, status, control; write update.
// - Writes allowed only with factory image loaded in remote update mode.
// - Writes blocked in local mode and for application images in remote mode.
// - Control holds page address, watchdog settings and application-not-factory flag.
// - Read in application image copies control register into shift register.
// - Reconfiguration in remote mode copies update register into control register.
// - Update register changes only by factory shift then update operation.
// - Read in factory image copies update register into shift register.
// - Every reconfiguration writes its cause into the status register.
// - Capture cycle with SHIFT_IN low loads status register into shift register.
// - Control and status registers run on the 10 MHz oscillator.
// - Shift and update registers run on the user-supplied shift clock.
// - Status is five cause flags, all zero after power-on.
// - Power-up page is zero in remote mode, one in local mode.
// - Watchdog field gives top 12 bits of 29-bit count, low 17 zero.
`timescale 1ns/1ns
`default_nettype none
module rup_path
   import rup_pkg::*;
(
   // System
   input wire logic CLK,
   input wire logic RST_B,
   // Mode strap: high for remote update, low for local update
   input wire logic REMOTE_MODE,
   // User shift port (asynchronous pins)
   input wire logic UPGRADE_SHIFT_CLOCK,
   input wire logic SHIFT_EN,
   input wire logic CAPTURE,
   input wire logic UPDATE,
   input wire logic SHIFT_IN,
   output logic SHIFT_OUT,
   // Reconfiguration trigger and causes
   input wire logic RECONFIG,
   input wire logic [4:0] CAUSE,
   // Observation
   output logic [20:0] CONTROL,
   output logic [4:0] STATUS,
   output logic [28:0] WD_COUNT,
   output logic WD_ENABLE,
   output logic WRITE_OK
);
   logic [4:0] s1;
   logic [4:0] s2;
   logic [4:0] s3;
   logic [20:0] shreg;
   logic [20:0] next_shreg;
   logic [20:0] upd;
   logic [20:0] next_upd;
   logic [20:0] ctrl_sync;
   logic [4:0] stat_sync;
   logic [20:0] next_ctrl_sync;
   logic [4:0] next_stat_sync;
   logic [3:0] div;
   logic [3:0] next_div;
   logic osc_en;
   logic remote_q;
   logic next_remote_q;
   logic write_ok;
   logic uclk_rise;
   logic capture_hi;
   logic remote_s1;
   rup_xfer_if xf ();

   // Two-flop synchronisers on user pins except SHIFT_IN; third stage for edge detect
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= {RECONFIG, UPGRADE_SHIFT_CLOCK, SHIFT_EN, CAPTURE, UPDATE};
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign uclk_rise = s2[3] & ~s3[3];
   assign capture_hi = s2[1];

   // Oscillator tick derived from CLK
   always_comb begin
      next_div = (div == 4'(OSC_DIV - 1)) ? 4'h0 : div + 4'h1;
   end
   assign osc_en = (div == 4'(OSC_DIV - 1));

   // Write gate: factory image in remote update mode only
   assign write_ok = remote_q & ~ctrl_sync[ANF_BIT];

   always_comb begin
      next_shreg = shreg;
      next_upd = upd;
      // Mode strap pin crosses in through two flops before gating writes
      next_remote_q = remote_s1;
      if (uclk_rise) begin
         if (s2[2]) begin
            next_shreg = {SHIFT_IN, shreg[20:1]};
         end else if (capture_hi) begin
            // Capture: status first, then the read source by image type
            next_shreg = '0;
            next_shreg[STAT_W-1:0] = stat_sync;
            if (SHIFT_IN) begin
               next_shreg = ctrl_sync[ANF_BIT] ? ctrl_sync : upd;
            end
         end else if (s2[0] && write_ok) begin
            next_upd = shreg;
         end
      end
   end

   // Oscillator-side values re-sampled only on the tick after they settle
   always_comb begin
      next_ctrl_sync = ctrl_sync;
      next_stat_sync = stat_sync;
      if (osc_en) begin
         next_ctrl_sync = xf.control_word;
         next_stat_sync = xf.status_word;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         shreg <= '0;
         upd <= '0;
         div <= '0;
         ctrl_sync <= '0;
         stat_sync <= STAT_RST;
         remote_q <= 1'b0;
         remote_s1 <= 1'b0;
      end else begin
         shreg <= next_shreg;
         upd <= next_upd;
         div <= next_div;
         ctrl_sync <= next_ctrl_sync;
         stat_sync <= next_stat_sync;
         remote_s1 <= REMOTE_MODE;
         remote_q <= next_remote_q;
      end
   end

   // Update word is held stable by the user while reconfig is pending
   assign xf.update_word = upd;

   rup_osc_regs u_osc (
      .clk(CLK),
      .rst_b(RST_B),
      .osc_en(osc_en),
      .remote_mode(REMOTE_MODE),
      .reconfig_req(s2[4]),
      .cause(CAUSE),
      .xf(xf)
   );

   assign SHIFT_OUT = shreg[0];
   assign CONTROL = ctrl_sync;
   assign STATUS = stat_sync;
   assign WD_COUNT = {ctrl_sync[WDT_LO +: WDT_W], {WDT_PAD{1'b0}}};
   assign WD_ENABLE = ctrl_sync[WDEN_BIT] & ctrl_sync[ANF_BIT];
   assign WRITE_OK = write_ok;
endmodule
`default_nettype wire

// ==== verilog/rup_pkg.sv ====
package rup_pkg;
   localparam int CTRL_W = 21;
   localparam int STAT_W = 5;
   // Control / update register field positions
   localparam int ANF_BIT = 0;
   localparam int PAGE_LO = 1;
   localparam int PAGE_W = 7;
   localparam int WDEN_BIT = 8;
   localparam int WDT_LO = 9;
   localparam int WDT_W = 12;
   localparam int WDT_PAD = 17;
   localparam int WDT_CNT_W = 29;
   // Status register bit positions
   localparam int ST_CRC = 0;
   localparam int ST_NSTAT = 1;
   localparam int ST_CORE = 2;
   localparam int ST_NCFG = 3;
   localparam int ST_WD = 4;
   localparam logic [6:0] PAGE_FACTORY = 7'h00;
   localparam logic [6:0] PAGE_APP = 7'h01;
   localparam logic [4:0] STAT_RST = 5'h00;
   // Oscillator enable: 100 MHz / 10 MHz
   localparam int CLK_MHZ = 100;
   localparam int OSC_MHZ = 10;
   localparam int OSC_DIV = CLK_MHZ / OSC_MHZ;
   typedef enum logic [1:0] {RUP_SRC_NONE, RUP_SRC_CTRL, RUP_SRC_UPD, RUP_SRC_STAT} rup_src_type;
endpackage

// ==== verilog/rup_xfer_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface rup_xfer_if;
   logic [20:0] update_word;
   logic [20:0] control_word;
   logic [4:0] status_word;
   logic reconfig_pulse;
   modport shift_side (output update_word, input control_word, input status_word,
      input reconfig_pulse);
   modport osc_side (input update_word, output control_word, output status_word,
      output reconfig_pulse);
endinterface
`default_nettype wire

// ==== verilog/rup_osc_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module rup_osc_regs
   import rup_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic osc_en,
   // Mode and causes
   input wire logic remote_mode,
   input wire logic reconfig_req,
   input wire logic [4:0] cause,
   rup_xfer_if.osc_side xf
);
   logic [20:0] ctrl;
   logic [20:0] next_ctrl;
   logic [4:0] stat;
   logic [4:0] next_stat;
   logic pend;
   logic next_pend;
   logic strap_done;
   logic next_strap_done;

   always_comb begin
      next_ctrl = ctrl;
      next_stat = stat;
      next_pend = pend | reconfig_req;
      next_strap_done = 1'b1;
      if (!strap_done) begin
         // Power-up page: factory in remote mode, application in local mode
         next_ctrl = '0;
         next_ctrl[PAGE_LO +: PAGE_W] = remote_mode ? PAGE_FACTORY : PAGE_APP;
         next_ctrl[ANF_BIT] = ~remote_mode;
      end else if (osc_en && pend) begin
         // Control and status change only on the oscillator tick once the power-up strap load is done
         next_pend = reconfig_req;
         next_stat = cause;
         if (remote_mode) begin
            next_ctrl = xf.update_word;
         end else begin
            // Local mode falls back to factory on CRC or nSTATUS causes, else reloads page one
            next_ctrl = '0;
            if (cause[ST_CRC] | cause[ST_NSTAT]) begin
               next_ctrl[PAGE_LO +: PAGE_W] = PAGE_FACTORY;
            end else begin
               next_ctrl[PAGE_LO +: PAGE_W] = PAGE_APP;
               next_ctrl[ANF_BIT] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= '0;
         stat <= STAT_RST;
         pend <= 1'b0;
         strap_done <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         stat <= next_stat;
         pend <= next_pend;
         strap_done <= next_strap_done;
      end
   end

   assign xf.control_word = ctrl;
   assign xf.status_word = stat;
   assign xf.reconfig_pulse = osc_en & pend & strap_done;
endmodule
`default_nettype wire

// ==== verif/rup_path_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module rup_path_chk
   import rup_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic REMOTE_MODE,
   input wire logic RECONFIG,
   input wire logic [4:0] CAUSE,
   input wire logic [20:0] CONTROL,
   input wire logic [4:0] STATUS,
   input wire logic [28:0] WD_COUNT,
   input wire logic WD_ENABLE,
   input wire logic WRITE_OK
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   a_write_gate: assert property (WRITE_OK && $stable(CONTROL) |->
      REMOTE_MODE && !CONTROL[ANF_BIT]) else $error("write gate");
   a_app_locked: assert property (CONTROL[ANF_BIT] && $stable(CONTROL) |->
      !WRITE_OK) else $error("app write");
   a_local_locked: assert property (!REMOTE_MODE |-> !WRITE_OK) else $error("local");
   a_wd_enable: assert property ($stable(CONTROL) |->
      WD_ENABLE == (CONTROL[WDEN_BIT] && CONTROL[ANF_BIT])) else $error("wd enable");
   a_wd_count: assert property ($stable(CONTROL) |->
      WD_COUNT == {CONTROL[20:9], 17'h0}) else $error("wd count");
   a_stat_load: assert property ($rose(RECONFIG) |-> ##[1:40] STATUS == CAUSE)
      else $error("cause");
   a_stat_por: assert property ($rose(RST_B) |-> STATUS == STAT_RST)
      else $error("status reset");
   a_local_page: assert property ($rose(RST_B) && !REMOTE_MODE |->
      ##[1:20] CONTROL[7:0] == 8'h03) else $error("local page");
   c_reconfig: cover property ($rose(RECONFIG));
   c_closed: cover property ($fell(WRITE_OK));
   c_local: cover property (!REMOTE_MODE && CONTROL[ANF_BIT]);
endmodule
bind rup_path rup_path_chk u_chk (.*);
`default_nettype wire

// ==== verif/rup_user.sv ====
`timescale 1ns/1ns
`default_nettype none
module rup_user (
   // Shift port towards the block
   output logic UPGRADE_SHIFT_CLOCK,
   output logic SHIFT_EN,
   output logic CAPTURE,
   output logic UPDATE,
   output logic SHIFT_IN,
   input wire logic SHIFT_OUT
);
   logic bit_seen;
   initial {UPGRADE_SHIFT_CLOCK, SHIFT_EN, CAPTURE, UPDATE, SHIFT_IN} = 5'h00;
   // 80 ns period, clock stays low between frames
   task pulse;
      #40 bit_seen = SHIFT_OUT;
      UPGRADE_SHIFT_CLOCK = 1'b1;
      #40 UPGRADE_SHIFT_CLOCK = 1'b0;
   endtask
   task shift_word(input logic [20:0] w, output logic [20:0] r);
      for (int i = 0; i < 21; i++) begin
         {SHIFT_EN, SHIFT_IN} = {1'b1, w[i]};
         pulse();
         r[i] = bit_seen;
      end
      SHIFT_EN = 1'b0;
   endtask
   task act(input logic cap, input logic upd, input logic sel);
      {CAPTURE, UPDATE, SHIFT_IN} = {cap, upd, sel};
      pulse();
      {CAPTURE, UPDATE} = 2'b00;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [20:0] WORD_A = {12'habc, 1'b1, 7'h05, 1'b1};
   logic CLK = 1'b0, RST_B, REMOTE_MODE, RECONFIG, SHIFT_OUT, WD_ENABLE, WRITE_OK;
   logic UPGRADE_SHIFT_CLOCK, SHIFT_EN, CAPTURE, UPDATE, SHIFT_IN;
   logic [4:0] CAUSE, STATUS;
   logic [20:0] CONTROL, rd;
   logic [28:0] WD_COUNT;
   int failures = 0, checks_done = 0;
   rup_path uut (.*);
   rup_user usr (.*);
   initial forever #5 CLK = ~CLK;
   task check(input logic [28:0] got, input logic [28:0] exp);
      checks_done++;
      failures += int'(got !== exp);
      if (got !== exp)
         $display("ERROR %0t got %h exp %h", $time, got, exp);
   endtask
   task test_done;
      $display("failures %0d checks_done %0d", failures, checks_done);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task do_reset(input logic mode, input logic [20:0] page);
      {RST_B, REMOTE_MODE} = {1'b0, mode};
      repeat (8) @(posedge CLK);
      #1 RST_B = 1'b1;
      repeat (20) @(posedge CLK);
      #1 check(CONTROL, page);
   endtask
   task reconfig(input logic [4:0] why, input logic [20:0] exp);
      {CAUSE, RECONFIG} = {why, 1'b1};
      repeat (2) @(posedge CLK);
      #1 RECONFIG = 1'b0;
      repeat (30) @(posedge CLK);
      #1 check(CONTROL, exp);
   endtask
   // Factory writes the update word, then the application may only read
   task t_factory_then_app;
      check(WRITE_OK, 1'b1);
      usr.shift_word(WORD_A, rd);
      usr.act(1'b0, 1'b1, 1'b0);
      usr.act(1'b1, 1'b0, 1'b1);
      usr.shift_word(21'h0f0f0, rd);
      check(rd, WORD_A);
      reconfig(5'h04, WORD_A);
      check(WRITE_OK, 1'b0);
      check(WD_COUNT, {12'habc, 17'h0});
      check(WD_ENABLE, 1'b1);
      check(STATUS, 5'h04);
      usr.act(1'b1, 1'b0, 1'b0);
      usr.shift_word(21'h0f0f0, rd);
      check(rd, 21'h04);
      usr.act(1'b0, 1'b1, 1'b0);
      reconfig(5'h08, WORD_A);
   endtask
   task t_local;
      do_reset(1'b0, 21'h3);
      usr.act(1'b1, 1'b0, 1'b1);
      usr.shift_word(21'h0, rd);
      check(rd, 21'h3);
      check(WRITE_OK, 1'b0);
      check(STATUS, 5'h00);
   endtask
   initial begin
      {RECONFIG, CAUSE} = 6'h00;
      do_reset(1'b1, 21'h0);
      t_factory_then_app();
      t_local();
      test_done();
   end
endmodule
`default_nettype wire
